// File: dcc_channel_control.sv
// Converter channel control: AHB-Lite register slave, trigger, noise, DMA.
// Assumes all inputs synchronous to clk; one AHB-Lite slave on its bus.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps

module dcc_channel_control
    import dcc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Trigger and DMA
    input  wire logic        hardwareTriggerInput,
    input  wire logic        dmaAck,
    output logic             dmaReq,
    output logic             underrunIrq,
    // Analog macro
    output logic             analogPowerUp,
    output logic             channelReady,
    output logic             outputBufferDisable,
    output logic             pinConnect,
    output logic             comparatorConnect,
    output logic      [11:0] outData,
    output logic             outLoad
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [31:0] ctrlReg_r;
    logic [11:0] holdData_r;
    logic        holdDirty_r;
    logic        swTrig_r;
    logic        underrunFlag_r;
    logic        hwTrigPrev_r;
    logic        wrPend_r;
    dcc_reg_e    wrSel_r;
    logic [31:0] hrdata_r;
    logic        hreadyout_r;
    logic        dmaReq_r;
    logic        underrunIrq_r;
    logic        powerUp_r;
    logic        ready_r;
    logic        bufDis_r;
    logic        pin_r;
    logic        comp_r;
    logic [11:0] outData_r;
    logic        outLoad_r;
    logic [15:0] wakeCnt_r;

    logic        busAccept;
    logic        wordOk;
    logic        hwEdge;
    logic        trigEvent;
    logic        xfer;
    logic        dmaArm;
    logic [1:0]  triggerSourceSelect;
    logic [12:0] sum;
    logic [31:0] readMux;
    dcc_reg_e    addrSel;

    dcc_noise_if nif ();

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic dcc_reg_e regSel(input logic [31:0] addr);
        dcc_reg_e sel;
        sel = REG_NONE;
        if (addr[7:0] == CTRL_OFS) begin
            sel = REG_CTRL;
        end else if (addr[7:0] == HOLD_OFS) begin
            sel = REG_HOLD;
        end else if (addr[7:0] == SWTRIG_OFS) begin
            sel = REG_SWT;
        end else if (addr[7:0] == STAT_OFS) begin
            sel = REG_STAT;
        end else if (addr[7:0] == DOUT_OFS) begin
            sel = REG_DOUT;
        end
        if (addr[31:8] != 24'h000000) begin
            sel = REG_NONE;
        end
        return sel;
    endfunction : regSel

    assign busAccept = hsel && htrans[1] && hready;
    assign wordOk    = (hsize == HSIZE_WORD) && (haddr[1:0] == 2'h0);
    assign addrSel   = regSel(haddr);

    always_comb begin
        readMux = 32'h0000_0000;
        case (addrSel)
            REG_CTRL: readMux = ctrlReg_r;
            REG_HOLD: readMux = {20'h00000, holdData_r};
            REG_STAT: readMux = {31'h0000_0000, underrunFlag_r};
            REG_DOUT: readMux = {20'h00000, outData_r};
            default:  readMux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // AHB-Lite slave, zero wait states, always OKAY
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPend_r    <= 1'b0;
            wrSel_r     <= REG_NONE;
            hrdata_r    <= 32'h0000_0000;
            hreadyout_r <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
            wrPend_r    <= busAccept && hwrite && wordOk;
            wrSel_r     <= addrSel;
            hrdata_r    <= (busAccept && !hwrite && wordOk) ? readMux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Registers written by software
    // ------------------------------------------------------------------
    // Control word, reserved bits zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrlReg_r <= CTRL_RESET;
        end else if (wrPend_r && wrSel_r == REG_CTRL) begin
            ctrlReg_r <= hwdata & CTRL_WMASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            holdData_r <= 12'h000;
        end else if (wrPend_r && wrSel_r == REG_HOLD) begin
            holdData_r <= hwdata[11:0];
        end
    end

    // Held data waits for an automatic transfer; a new write wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            holdDirty_r <= 1'b0;
        end else if (wrPend_r && wrSel_r == REG_HOLD) begin
            holdDirty_r <= 1'b1;
        end else if (xfer) begin
            holdDirty_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            swTrig_r <= 1'b0;
        end else begin
            swTrig_r <= wrPend_r && wrSel_r == REG_SWT && hwdata[SWT_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Trigger selection and transfer
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hwTrigPrev_r <= 1'b0;
        end else begin
            hwTrigPrev_r <= hardwareTriggerInput;
        end
    end

    assign hwEdge              = hardwareTriggerInput && !hwTrigPrev_r;
    assign triggerSourceSelect = ctrlReg_r[TSEL_LO +: 2];

    assign trigEvent = ctrlReg_r[BIT_TEN]
                     && ((triggerSourceSelect == TSEL_HW && hwEdge)
                      || (triggerSourceSelect == TSEL_SW && swTrig_r));
    assign xfer      = ctrlReg_r[BIT_TEN] ? trigEvent : holdDirty_r;

    assign nif.mode      = ctrlReg_r[BIT_TEN] ? ctrlReg_r[MODE_LO +: 2] : MODE_NONE;
    assign nif.widthCode = ctrlReg_r[WID_LO +: 4];
    assign nif.step      = xfer;

    dcc_noise_gen u_noise (
        .clk (clk),
        .rst (rst),
        .nif (nif)
    );

    assign sum = {1'b0, holdData_r} + {1'b0, nif.noise};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outData_r <= 12'h000;
            outLoad_r <= 1'b0;
        end else begin
            outLoad_r <= xfer;
            if (xfer) begin
                outData_r <= sum[12] ? 12'hfff : sum[11:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // DMA request and underrun
    // ------------------------------------------------------------------
    // Requests only with DMA mode
    assign dmaArm = ctrlReg_r[BIT_DMAEN] && ctrlReg_r[BIT_TEN]
                  && triggerSourceSelect == TSEL_HW && hwEdge;

    // Drop request while pending or stalled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dmaReq_r <= 1'b0;
        end else if (dmaReq_r && dmaAck) begin
            dmaReq_r <= 1'b0;
        end else if (dmaArm && !dmaReq_r && !underrunFlag_r) begin
            dmaReq_r <= 1'b1;
        end
    end

    // Underrun flag, set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            underrunFlag_r <= 1'b0;
        end else if (dmaArm && dmaReq_r && !dmaAck) begin
            underrunFlag_r <= 1'b1;
        end else if (wrPend_r && wrSel_r == REG_STAT && hwdata[STAT_UDR]) begin
            underrunFlag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            underrunIrq_r <= 1'b0;
        end else begin
            underrunIrq_r <= underrunFlag_r && ctrlReg_r[BIT_UDRIE];
        end
    end

    // ------------------------------------------------------------------
    // Analog controls
    // ------------------------------------------------------------------
    // Power-up and wake-up count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            powerUp_r <= 1'b0;
            wakeCnt_r <= 16'h0000;
            ready_r   <= 1'b0;
        end else begin
            powerUp_r <= ctrlReg_r[BIT_EN];
            if (!ctrlReg_r[BIT_EN]) begin
                wakeCnt_r <= 16'h0000;
                ready_r   <= 1'b0;
            end else if (wakeCnt_r < 16'(WAKEUP_CYC)) begin
                wakeCnt_r <= wakeCnt_r + 16'h0001;
            end else begin
                ready_r   <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bufDis_r <= 1'b0;
            pin_r    <= 1'b1;
            comp_r   <= 1'b1;
        end else begin
            bufDis_r <= ctrlReg_r[BIT_BOFF];
            pin_r    <= !(ctrlReg_r[BIT_CMPONLY] && ctrlReg_r[BIT_BOFF]);
            comp_r   <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign hrdata              = hrdata_r;
    assign hreadyout           = hreadyout_r;
    assign hresp               = 1'b0;
    assign dmaReq              = dmaReq_r;
    assign underrunIrq         = underrunIrq_r;
    assign analogPowerUp       = powerUp_r;
    assign channelReady        = ready_r;
    assign outputBufferDisable = bufDis_r;
    assign pinConnect          = pin_r;
    assign comparatorConnect   = comp_r;
    assign outData             = outData_r;
    assign outLoad             = outLoad_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ctrl_reset_zero_a: assert property ($past(rst) |-> ctrlReg_r == CTRL_RESET)
        else $error("control word not zero after reset");

    ctrl_word_write_a: assert property (
        busAccept && hwrite && !wordOk |=> ##1 $stable(ctrlReg_r))
        else $error("partial access changed control word");

    route_comp_only_a: assert property (
        ctrlReg_r[BIT_CMPONLY] && ctrlReg_r[BIT_BOFF] |=> !pinConnect && comparatorConnect)
        else $error("pin not released for comparator-only route");

    irq_gate_a: assert property (underrunIrq |-> $past(ctrlReg_r[BIT_UDRIE]))
        else $error("interrupt raised while disabled");

    dma_enable_gate_a: assert property ($rose(dmaReq) |-> $past(ctrlReg_r[BIT_DMAEN]))
        else $error("DMA request without DMA mode");

    buffer_disable_a: assert property ($changed(ctrlReg_r[BIT_BOFF])
        |=> outputBufferDisable == $past(ctrlReg_r[BIT_BOFF]))
        else $error("buffer disable does not follow control bit");

    trig_load_a: assert property (
        outLoad && $past(ctrlReg_r[BIT_TEN]) |-> $past(hwEdge || swTrig_r))
        else $error("triggered load without a trigger");

    underrun_drop_a: assert property (
        dmaArm && dmaReq_r && !dmaAck |=> underrunFlag_r && dmaReq ##1 !$rose(dmaReq))
        else $error("second trigger not dropped as underrun");

    wakeup_time_a: assert property ($rose(channelReady) |-> analogPowerUp
        && wakeCnt_r == 16'(WAKEUP_CYC))
        else $error("channel ready before wake-up time");

endmodule : dcc_channel_control

// File: dcc_dma_model.sv
// DMA controller model: answers each request after a chosen delay.
// Assumes requests are levels held until acknowledged.
`timescale 1ns/1ps

module dcc_dma_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Request side
    input  wire logic       dmaReq,
    input  wire logic [7:0] ackDelay,
    output logic            dmaAck
);
    logic [7:0] waitCnt;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dmaAck  <= 1'b0;
            waitCnt <= 8'h00;
        end else if (dmaAck || !dmaReq) begin
            dmaAck  <= 1'b0;
            waitCnt <= 8'h00;
        end else if (waitCnt == ackDelay) begin
            dmaAck <= 1'b1;
        end else begin
            waitCnt <= waitCnt + 8'h01;
        end
    end
endmodule : dcc_dma_model

// File: dcc_noise_gen.sv
// Noise wave generator: LFSR and triangle sources masked to the chosen width.
// Assumes mode is forced to none by the controller while the trigger is off.
`timescale 1ns/1ps

module dcc_noise_gen
    import dcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controller side
    dcc_noise_if.gen nif
);

    logic [11:0] lfsr_r;
    logic [11:0] triVal_r;
    logic        triDown_r;
    logic [3:0]  widthN;
    logic [11:0] widthMask;
    logic        lfsrFb;

    // ------------------------------------------------------------------
    // Width decode
    // ------------------------------------------------------------------
    // Width from code
    assign widthN    = (nif.widthCode > WIDTH_MAX_CODE) ? WIDTH_FULL : nif.widthCode + 4'h1;
    assign widthMask = 12'hfff >> (WIDTH_FULL - widthN);

    // ------------------------------------------------------------------
    // LFSR
    // ------------------------------------------------------------------
    assign lfsrFb = lfsr_r[11] ^ lfsr_r[5] ^ lfsr_r[3] ^ lfsr_r[0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lfsr_r <= LFSR_SEED;
        end else if (nif.step && nif.mode == MODE_LFSR) begin
            lfsr_r <= {lfsr_r[10:0], lfsrFb};
        end
    end

    // ------------------------------------------------------------------
    // Triangle
    // ------------------------------------------------------------------
    // Triangle up and down
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            triVal_r  <= 12'h000;
            triDown_r <= 1'b0;
        end else if (nif.mode == MODE_NONE) begin
            triVal_r  <= 12'h000;
            triDown_r <= 1'b0;
        end else if (nif.step && nif.mode[1]) begin
            if (!triDown_r && triVal_r >= widthMask) begin
                triDown_r <= 1'b1;
                triVal_r  <= widthMask - 12'h001;
            end else if (!triDown_r) begin
                triVal_r  <= triVal_r + 12'h001;
            end else if (triVal_r == 12'h000) begin
                triDown_r <= 1'b0;
                triVal_r  <= 12'h001;
            end else begin
                triVal_r  <= triVal_r - 12'h001;
            end
        end
    end

    always_comb begin
        if (nif.mode == MODE_NONE) begin
            nif.noise = 12'h000;
        end else if (nif.mode == MODE_LFSR) begin
            nif.noise = lfsr_r & widthMask;
        end else begin
            nif.noise = (triVal_r > widthMask) ? widthMask : triVal_r;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    noise_width_mask_a: assert property ((nif.noise & ~widthMask) == 12'h000)
        else $error("noise exceeds selected width");

    tri_step_up_a: assert property (
        nif.step && nif.mode == 2'h2 && !triDown_r && triVal_r < widthMask
        |=> triVal_r == $past(triVal_r) + 12'h001)
        else $error("triangle did not count up");

    tri_peak_turn_a: assert property (
        nif.step && nif.mode[1] && !triDown_r && triVal_r == widthMask
        && $stable(nif.mode) |=> triDown_r)
        else $error("triangle did not turn at peak");

endmodule : dcc_noise_gen

// File: dcc_noise_if.sv
// Interface between channel control and its noise generator.
// Assumes both ends share the channel clock.
`timescale 1ns/1ps

interface dcc_noise_if;
    logic [1:0]  mode;
    logic [3:0]  widthCode;
    logic        step;
    logic [11:0] noise;

    modport ctl (output mode, output widthCode, output step, input noise);
    modport gen (input mode, input widthCode, input step, output noise);
endinterface : dcc_noise_if

// File: dcc_pkg.sv
// Constants, register map and types for the converter channel control block.
// Assumes a single 100 MHz clock and an AHB-Lite register bus with 32-bit data.
//
// Summary of operation
// - Control word at offset zero, reachable only by aligned 32-bit word accesses.
// - Control word reads zero after reset; everything starts disabled, buffer on.
// - Bit 14 with buffer off routes output to comparator only; else pin too.
// - Bit 13 gates the underrun flag onto the interrupt output.
// - Bit 12 enables DMA requests; none are issued while it is zero.
// - Width code k gives k+1 noise bits; codes eleven and above give 12.
// - LFSR mode adds only the low n LFSR bits; upper bits masked.
// - Triangle mode counts zero up to 2^n-1 and back down to zero.
// - Mode field: 00 none, 01 LFSR, 1x triangle; only while trigger enabled.
// - Source field: 00 hardware trigger, 01 software trigger; others reserved.
// - With bit 2 set, held data moves to output only on selected trigger.
// - Bit 1 drives the output buffer disable signal to the analog macro.
// - Channel enable powers up the converter; output usable after a wake-up time.
// - Transfer held data plus noise on trigger; automatic when trigger disabled.
// - Hardware trigger before DMA acknowledge drops request, sets underrun, stalls DMA.

package dcc_pkg;

    // ------------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFS   = 8'h00;
    localparam logic [7:0]  HOLD_OFS   = 8'h40;
    localparam logic [7:0]  SWTRIG_OFS = 8'h44;
    localparam logic [7:0]  STAT_OFS   = 8'h48;
    localparam logic [7:0]  DOUT_OFS   = 8'h4c;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_7fdf;
    localparam logic [2:0]  HSIZE_WORD = 3'h2;

    // ------------------------------------------------------------------
    // Control word fields
    // ------------------------------------------------------------------
    localparam int BIT_EN      = 0;
    localparam int BIT_BOFF    = 1;
    localparam int BIT_TEN     = 2;
    localparam int TSEL_LO     = 3;
    localparam int MODE_LO     = 6;
    localparam int WID_LO      = 8;
    localparam int BIT_DMAEN   = 12;
    localparam int BIT_UDRIE   = 13;
    localparam int BIT_CMPONLY = 14;
    localparam int STAT_UDR    = 0;
    localparam int SWT_BIT     = 0;

    localparam logic [1:0]  TSEL_HW        = 2'h0;
    localparam logic [1:0]  TSEL_SW        = 2'h1;
    localparam logic [1:0]  MODE_NONE      = 2'h0;
    localparam logic [1:0]  MODE_LFSR      = 2'h1;
    localparam logic [3:0]  WIDTH_MAX_CODE = 4'ha;
    localparam logic [3:0]  WIDTH_FULL     = 4'hc;
    localparam logic [11:0] LFSR_SEED      = 12'haaa;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_NS     = 10;
    localparam int WAKEUP_NS  = 1000;
    localparam int WAKEUP_CYC = (WAKEUP_NS + CLK_NS - 1) / CLK_NS;

    typedef enum {REG_CTRL, REG_HOLD, REG_SWT, REG_STAT, REG_DOUT, REG_NONE} dcc_reg_e;

endpackage : dcc_pkg

// File: tb.sv
// Testbench for the converter channel control block.
// Assumes the DMA model answers requests; the bench is the trigger unit.
`timescale 1ns/1ps

module tb;
    import dcc_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, hsel = 1'b1, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic        hreadyout, hresp, dmaAck, dmaReq, underrunIrq, outLoad;
    logic        analogPowerUp, channelReady, outputBufferDisable;
    logic        pinConnect, comparatorConnect, hardwareTriggerInput = 1'b0;
    logic [11:0] outData;
    logic [7:0]  ackDelay = 8'h00;
    int          numErrors = 0, totalChecks = 0;

    dcc_channel_control i_dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .hardwareTriggerInput, .dmaAck, .dmaReq, .underrunIrq, .analogPowerUp,
        .channelReady, .outputBufferDisable, .pinConnect, .comparatorConnect,
        .outData, .outLoad);
    dcc_dma_model i_dma (.clk, .rst, .dmaReq, .ackDelay, .dmaAck);

    always #5 clk = ~clk;

    // ----------------------------------------
    // Bus and check helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [31:0] a, d, input logic [2:0] sz);
        @(posedge clk);
        haddr  <= a;
        hwrite <= w;
        hsize  <= sz;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [31:0] a, d);
        bus(1'b1, a, d, HSIZE_WORD);
        repeat (3) @(posedge clk);
    endtask : wr

    task automatic hwPulse();
        @(posedge clk);
        hardwareTriggerInput <= 1'b1;
        @(posedge clk);
        hardwareTriggerInput <= 1'b0;
        repeat (5) @(posedge clk);
    endtask : hwPulse

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic testRegs();
        bus(1'b0, CTRL_OFS, 0, HSIZE_WORD);
        chk(rd, 32'h0);
        chk({pinConnect, outputBufferDisable, dmaReq, analogPowerUp}, 4'h8);
        wr(CTRL_OFS, 32'h0000_7fdf);
        bus(1'b1, CTRL_OFS, 0, 3'h0);
        bus(1'b0, CTRL_OFS, 0, HSIZE_WORD);
        chk(rd, 32'h0000_7fdf);
        bus(1'b0, CTRL_OFS, 0, 3'h1);
        chk(rd, 32'h0);
        bus(1'b0, 32'h100, 0, HSIZE_WORD);
        chk(rd, 32'h0);
        chk(hresp, 1'b0);
        wr(CTRL_OFS, 32'h0);
        $display("regs done");
    endtask : testRegs

    task automatic testRoute();
        for (int i = 0; i < 4; i++) begin
            wr(CTRL_OFS, {17'h0, i[1], 12'h0, i[0], 1'b0});
            chk(outputBufferDisable, i[0]);
            chk(pinConnect, !(i[0] && i[1]));
            chk(comparatorConnect, 1'b1);
        end
        $display("route done");
    endtask : testRoute

    task automatic testPower();
        int n;
        bus(1'b1, CTRL_OFS, 32'h1, HSIZE_WORD);
        n = 0;
        while (channelReady !== 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        chk(analogPowerUp, 1'b1);
        chk(n >= WAKEUP_CYC - 1 && n <= WAKEUP_CYC + 3, 1'b1);
        wr(CTRL_OFS, 32'h0);
        chk(channelReady, 1'b0);
        $display("power done");
    endtask : testPower

    task automatic testTrig();
        wr(CTRL_OFS, 32'h0000_0b40);
        wr(HOLD_OFS, 32'h123);
        chk(outData, 12'h123);
        wr(CTRL_OFS, 32'h4);
        wr(HOLD_OFS, 32'h456);
        chk(outData, 12'h123);
        hwPulse();
        chk(outData, 12'h456);
        wr(CTRL_OFS, 32'h14);
        wr(HOLD_OFS, 32'h789);
        hwPulse();
        wr(SWTRIG_OFS, 32'h1);
        chk(outData, 12'h456);
        wr(CTRL_OFS, 32'hc);
        hwPulse();
        chk(outData, 12'h456);
        bus(1'b1, SWTRIG_OFS, 32'h1, HSIZE_WORD);
        repeat (2) @(posedge clk);
        chk(outLoad, 1'b1);
        @(posedge clk);
        chk(outLoad, 1'b0);
        chk(outData, 12'h789);
        $display("trigger done");
    endtask : testTrig

    task automatic testNoise();
        logic [11:0] top;
        wr(CTRL_OFS, 32'h4c);
        wr(HOLD_OFS, 32'h100);
        repeat (6) begin
            wr(SWTRIG_OFS, 32'h1);
            chk(outData & 12'hffe, 12'h100);
        end
        wr(CTRL_OFS, 32'h18c);
        wr(HOLD_OFS, 32'h0);
        top = 12'h0;
        repeat (10) begin
            wr(SWTRIG_OFS, 32'h1);
            chk(outData <= 12'h3, 1'b1);
            if (outData > top) top = outData;
        end
        chk(top, 12'h3);
        wr(HOLD_OFS, 32'hfff);
        wr(SWTRIG_OFS, 32'h1);
        chk(outData, 12'hfff);
        wr(CTRL_OFS, 32'h0000_0b4c);
        wr(HOLD_OFS, 32'h0);
        top = 12'h0;
        repeat (12) begin
            wr(SWTRIG_OFS, 32'h1);
            top = top | outData;
        end
        chk(top[11], 1'b1);
        $display("noise done");
    endtask : testNoise

    task automatic testDma();
        wr(CTRL_OFS, 32'h3004);
        hwPulse();
        hwPulse();
        chk(underrunIrq, 1'b0);
        ackDelay <= 8'd60;
        wr(CTRL_OFS, 32'h2004);
        hwPulse();
        chk(dmaReq, 1'b0);
        wr(CTRL_OFS, 32'h3004);
        hwPulse();
        chk(dmaReq, 1'b1);
        hwPulse();
        chk(underrunIrq, 1'b1);
        bus(1'b0, STAT_OFS, 0, HSIZE_WORD);
        chk(rd, 32'h1);
        repeat (70) @(posedge clk);
        hwPulse();
        chk(dmaReq, 1'b0);
        wr(CTRL_OFS, 32'h1004);
        chk(underrunIrq, 1'b0);
        wr(STAT_OFS, 32'h1);
        hwPulse();
        chk(dmaReq, 1'b1);
        repeat (70) @(posedge clk);
        $display("dma done");
    endtask : testDma

    task automatic testDone();
        $display("checks=%0d mismatches=%0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : testDone

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        testRegs();
        testRoute();
        testPower();
        testTrig();
        testNoise();
        testDma();
        testDone();
    end

    initial begin
        #200000;
        numErrors++;
        testDone();
    end
endmodule : tb
